// *** rtl/kbknob_regs.svh ***
// Register map, field positions, reset values and timing counts of the keyboard and knob register set
`ifndef KBKNOB_REGS_SVH
`define KBKNOB_REGS_SVH

`define KK_REG_CASE_LOCK      4'h0
`define KK_REG_PRINT_ECHO     4'h1
`define KK_REG_REPEAT_PERIOD  4'h3
`define KK_REG_REPEAT_DELAY   4'h4
`define KK_REG_INT_MASK       4'h7
`define KK_REG_LANGUAGE       4'h8
`define KK_REG_CONFIG         4'h9
`define KK_REG_KNOB_MODIFIER  4'ha
`define KK_REG_END_MARKER     4'hc
`define KK_REG_KANA_MODE      4'hd

`define KK_MASK_KEYS_BIT      0
`define KK_MASK_RESET_BIT     1
`define KK_MASK_INIT_TO_BIT   4
`define KK_MASK_USED          8'h1f
`define KK_MASK_RESET_VAL     8'h00

`define KK_PERIOD_RESET_VAL   16'h0008
`define KK_DELAY_RESET_VAL    16'h0046
`define KK_PERIOD_OFF_VAL     16'h0100

`define KK_LANG_KANA          3'h5
`define KK_LANG_MAX           3'h5
`define KK_CONFIG_MAX         4'h8

`define KK_CODE_PREFIX        8'hff
`define KK_CHAR_KNOB_CW       8'h5e
`define KK_CHAR_KNOB_CCW      8'h56
`define KK_KNOB_MAX           8'sh7f
`define KK_KNOB_MIN           8'sh81

// One repeat tick every 10 ms at 125 MHz
`define KK_TICK_MS            10
`define KK_CLK_KHZ            125000
`define KK_TICK_CYCLES        (`KK_TICK_MS * `KK_CLK_KHZ)

`endif

// *** rtl/kbknob_pkg.sv ***
// Types shared by the keyboard and knob register set
package kbknob_pkg;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic       is_ascii;
		logic       is_reset;
		logic       is_interactive;
		logic       is_softkey;
	} kbknob_key_t;

	typedef struct packed {
		logic valid;
		logic clockwise;
		logic shift;
		logic ctrl;
	} kbknob_pulse_t;

	typedef struct packed {
		logic        valid;
		logic        to_softkey;
		logic [7:0]  code;
	} kbknob_out_t;

	typedef enum logic [1:0] {
		KBKNOB_EMIT_IDLE   = 2'b00,
		KBKNOB_EMIT_CTRL   = 2'b01,
		KBKNOB_EMIT_PREFIX = 2'b10,
		KBKNOB_EMIT_CHAR   = 2'b11
	} kbknob_emit_t;

endpackage

// *** rtl/kbknob_tick.sv ***
// Free-running 10 ms tick divider for the auto-repeat timing
`timescale 1ns/10ps
`include "kbknob_regs.svh"
module kbknob_tick (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic arst_n,
	// Tick out
	output logic      tick
);
	localparam int unsigned TICK_LAST = `KK_TICK_CYCLES - 1;

	logic [20:0] cnt_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 21'h0;
			tick  <= 1'b0;
		end else begin
			tick <= (cnt_q == TICK_LAST[20:0]);
			if (cnt_q == TICK_LAST[20:0]) begin
				cnt_q <= 21'h0;
			end else begin
				cnt_q <= cnt_q + 21'h1;
			end
		end
	end
endmodule

// *** rtl/kbknob_knob.sv ***
// Signed net knob pulse counter, saturating at its documented range
`timescale 1ns/10ps
`include "kbknob_regs.svh"
module kbknob_knob (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	// Pulse in and read-and-clear
	input  wire logic             pulse,
	input  wire logic             clockwise,
	input  wire logic             read_clear,
	// Count out
	output logic signed [7:0]     count
);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= 8'sh00;
		end else if (read_clear) begin
			// A pulse in the read cycle starts the next interval
			if (pulse) begin
				count <= clockwise ? 8'sh01 : 8'shff;
			end else begin
				count <= 8'sh00;
			end
		end else if (pulse) begin
			if (clockwise && count != `KK_KNOB_MAX) begin
				count <= count + 8'sh01; // [RQ16]
			end else if (!clockwise && count != `KK_KNOB_MIN) begin
				count <= count - 8'sh01; // [RQ16]
			end
		end
	end
endmodule

// *** rtl/kbknob_ctrl.sv ***
// Keyboard and knob status/control register set with keystroke coding
// Overview of operation
// RQ1: Without knob trap, each knob pulse emits 255 then a direction character.
// RQ2: Control 7 bit 0 blocks all keys but reset, and the knob.
// RQ3: Mask bits disable sources: 0 keys/knob, 1 reset, 4 init timeout.
// RQ4: Register 0 reads case lock; non-zero write sets it.
// RQ5: Register 1 reads print echo; non-zero write sets it.
// RQ6: Control 3 sets repeat period 10 ms times value; 256 disables; reset 8.
// RQ7: Control 4 sets repeat delay 10 ms times value; reset 70.
// RQ8: Status 8 returns language jumper code 0 to 5.
// RQ9: Status 9 returns configuration jumper 0 to 8; control 9 ignored.
// RQ10: Status 10 holds shift and control latched at last knob pulse.
// RQ11: Control 12 non-zero enables control-E end marker; status 12 reports it.
// RQ12: Control 13 non-zero selects kana mode; status 13 reports it. The code selects kana only when the language jumper reads 5.
// RQ13: Suspension ignores interactive keys, optionally reset; resume restores them.
// RQ14: All-keys trapping sends softkeys to keystroke trap, labels unchanged.
// RQ15: Non-ASCII key emits 255 then character; control adds leading 255.
// RQ16: Knob counter holds signed net rotation, +127 to -127, 120 per turn.
// RQ17: Status 7 reads back the interrupt disable mask, upper bits zero.
`timescale 1ns/10ps
`include "kbknob_regs.svh"
module kbknob_ctrl (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  arst_n,
	// Host register port
	input  wire logic [3:0]            reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [15:0]           reg_wdata,
	output logic      [15:0]           reg_rdata,
	output logic                       reg_rvalid,
	// Knob count read
	input  wire logic                  knob_read,
	output logic      [7:0]            knob_pulse_count,
	// Operator side
	input  wire kbknob_pkg::kbknob_key_t   key_in,
	input  wire logic                  key_held,
	input  wire kbknob_pkg::kbknob_pulse_t knob_in,
	input  wire logic                  init_timeout,
	input  wire logic [2:0]            language_jumper,
	input  wire logic [3:0]            config_jumper,
	// Trap and mode control from the host
	input  wire logic                  knob_trap_active,
	input  wire logic                  kbd_trap_active,
	input  wire logic                  kbd_trap_all,
	input  wire logic                  suspend_interactive,
	input  wire logic                  suspend_reset,
	// Events to the host
	output kbknob_pkg::kbknob_out_t    key_out,
	output logic                       knob_event,
	output logic                       reset_event,
	output logic                       init_timeout_event,
	// Mode flags
	output logic                       letter_case_lock,
	output logic                       print_echo,
	output logic                       end_of_transfer_marker,
	output logic                       kana_mode
);
	logic [7:0]                  mask_q;
	logic [15:0]                 period_q;
	logic [15:0]                 delay_q;
	logic                        case_q;
	logic                        echo_q;
	logic                        eot_q;
	logic                        kana_q;
	logic [1:0]                  knob_mod_q;
	kbknob_pkg::kbknob_emit_t    emit_q;
	logic [7:0]                  emit_char_q;
	logic                        emit_soft_q;
	logic [15:0]                 rep_cnt_q;
	logic                        rep_started_q;
	kbknob_pkg::kbknob_key_t     last_key_q;
	logic                        tick_10ms;
	logic signed [7:0]           knob_count;

	function automatic logic nonzero(input logic [15:0] v);
		nonzero = |v;
	endfunction

	function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] r, input logic w);
		wr_hit = w && (a == r);
	endfunction

	wire keys_blocked  = mask_q[`KK_MASK_KEYS_BIT];
	wire reset_blocked = mask_q[`KK_MASK_RESET_BIT];
	wire knob_ok       = knob_in.valid && !keys_blocked; // [RQ2]
	wire key_ok        = key_in.valid && !key_in.is_reset && !keys_blocked
		&& !(suspend_interactive && key_in.is_interactive); // [RQ2] [RQ13]
	wire reset_ok      = key_in.valid && key_in.is_reset && !reset_blocked
		&& !(suspend_interactive && suspend_reset); // [RQ3] [RQ13]
	wire emit_free     = (emit_q == kbknob_pkg::KBKNOB_EMIT_IDLE);
	wire repeat_on     = (period_q != `KK_PERIOD_OFF_VAL) && (period_q != 16'h0);
	// Softkeys go to the trap only with all-keys trapping
	wire soft_now      = (key_ok ? key_in.is_softkey : last_key_q.is_softkey)
		&& !(kbd_trap_active && kbd_trap_all); // [RQ14]

	kbknob_tick i_kbknob_tick (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.tick    (tick_10ms)
	);

	kbknob_knob i_kbknob_knob (
		.sys_clk    (sys_clk),
		.arst_n     (arst_n),
		.pulse      (knob_ok),
		.clockwise  (knob_in.clockwise),
		.read_clear (knob_read),
		.count      (knob_count)
	);

	// Mode flags: a non-zero write sets, zero clears; kana sets only with the kana language jumper
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			case_q <= 1'b0;
			echo_q <= 1'b0;
			eot_q  <= 1'b0;
			kana_q <= 1'b0;
		end else begin
			if (wr_hit(reg_addr, `KK_REG_CASE_LOCK, reg_wr)) begin
				case_q <= nonzero(reg_wdata); // [RQ4]
			end
			if (wr_hit(reg_addr, `KK_REG_PRINT_ECHO, reg_wr)) begin
				echo_q <= nonzero(reg_wdata); // [RQ5]
			end
			if (wr_hit(reg_addr, `KK_REG_END_MARKER, reg_wr)) begin
				eot_q <= nonzero(reg_wdata); // [RQ11]
			end
			// Kana only takes effect with a kana keyboard fitted
			if (wr_hit(reg_addr, `KK_REG_KANA_MODE, reg_wr)) begin
				kana_q <= nonzero(reg_wdata) && (language_jumper == `KK_LANG_KANA); // [RQ12]
			end
		end
	end

	// Mask and repeat timing
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_q   <= `KK_MASK_RESET_VAL;
			period_q <= `KK_PERIOD_RESET_VAL;
			delay_q  <= `KK_DELAY_RESET_VAL;
		end else begin
			if (wr_hit(reg_addr, `KK_REG_INT_MASK, reg_wr)) begin
				mask_q <= reg_wdata[7:0] & `KK_MASK_USED; // [RQ2] [RQ3]
			end
			if (wr_hit(reg_addr, `KK_REG_REPEAT_PERIOD, reg_wr)) begin
				period_q <= reg_wdata; // [RQ6]
			end
			if (wr_hit(reg_addr, `KK_REG_REPEAT_DELAY, reg_wr)) begin
				delay_q <= reg_wdata; // [RQ7]
			end
		end
	end

	// Modifier state latched at each accepted knob pulse
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			knob_mod_q <= 2'b00;
		end else if (knob_ok) begin
			knob_mod_q <= {knob_in.ctrl, knob_in.shift}; // [RQ10]
		end
	end

	// Auto-repeat: delay ticks first, then period ticks while the key is held
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_key_q    <= '0;
			rep_cnt_q     <= 16'h0;
			rep_started_q <= 1'b0;
		end else if (key_ok && emit_free) begin
			last_key_q    <= key_in;
			rep_cnt_q     <= 16'h0;
			rep_started_q <= 1'b0;
		end else if (!key_held || keys_blocked) begin
			last_key_q.valid <= 1'b0;
		end else if (tick_10ms && last_key_q.valid && emit_free) begin
			if (!rep_started_q && rep_cnt_q + 16'h1 >= delay_q) begin
				rep_started_q <= 1'b1; // [RQ7]
				rep_cnt_q     <= 16'h0;
			end else if (rep_started_q && rep_cnt_q + 16'h1 >= period_q) begin
				rep_cnt_q <= 16'h0; // [RQ6]
			end else begin
				rep_cnt_q <= rep_cnt_q + 16'h1;
			end
		end
	end

	wire rep_fire = tick_10ms && last_key_q.valid && key_held && !keys_blocked && emit_free
		&& repeat_on && rep_started_q && (rep_cnt_q + 16'h1 >= period_q); // [RQ6]

	// Keystroke coding sequencer
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			emit_q      <= kbknob_pkg::KBKNOB_EMIT_IDLE;
			emit_char_q <= 8'h0;
			emit_soft_q <= 1'b0;
			key_out     <= '0;
		end else begin
			key_out.valid <= 1'b0;
			case (emit_q)
				kbknob_pkg::KBKNOB_EMIT_IDLE: begin
					if (knob_ok && !knob_trap_active) begin
						emit_char_q <= knob_in.clockwise ? `KK_CHAR_KNOB_CW : `KK_CHAR_KNOB_CCW; // [RQ1]
						emit_soft_q <= 1'b0;
						key_out     <= '{valid: 1'b1, to_softkey: 1'b0, code: `KK_CODE_PREFIX};
						emit_q      <= kbknob_pkg::KBKNOB_EMIT_CHAR; // [RQ1]
					end else if (key_ok || rep_fire) begin
						if (key_ok ? key_in.is_ascii : last_key_q.is_ascii) begin
							key_out <= '{valid: 1'b1, to_softkey: 1'b0,
								code: key_ok ? key_in.code : last_key_q.code};
						end else begin
							emit_char_q <= key_ok ? key_in.code : last_key_q.code;
							emit_soft_q <= soft_now; // [RQ14]
							// The whole code sequence follows one route
							key_out <= '{valid: 1'b1, to_softkey: soft_now, code: `KK_CODE_PREFIX};
							emit_q  <= knob_in.ctrl ? kbknob_pkg::KBKNOB_EMIT_CTRL
								: kbknob_pkg::KBKNOB_EMIT_CHAR; // [RQ15]
						end
					end
				end
				kbknob_pkg::KBKNOB_EMIT_CTRL: begin
					key_out <= '{valid: 1'b1, to_softkey: emit_soft_q, code: `KK_CODE_PREFIX}; // [RQ15]
					emit_q  <= kbknob_pkg::KBKNOB_EMIT_CHAR;
				end
				kbknob_pkg::KBKNOB_EMIT_CHAR: begin
					key_out <= '{valid: 1'b1, to_softkey: emit_soft_q, code: emit_char_q}; // [RQ15]
					emit_q  <= kbknob_pkg::KBKNOB_EMIT_IDLE;
				end
				default: begin
					emit_q <= kbknob_pkg::KBKNOB_EMIT_IDLE;
				end
			endcase
		end
	end

	// Events to the host, each gated by its mask bit
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			knob_event         <= 1'b0;
			reset_event        <= 1'b0;
			init_timeout_event <= 1'b0;
		end else begin
			knob_event         <= knob_ok && knob_trap_active; // [RQ2]
			reset_event        <= reset_ok; // [RQ3]
			init_timeout_event <= init_timeout && !mask_q[`KK_MASK_INIT_TO_BIT]; // [RQ3]
		end
	end

	// Register read port
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata  <= 16'h0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					`KK_REG_CASE_LOCK:     reg_rdata <= {15'h0, case_q}; // [RQ4]
					`KK_REG_PRINT_ECHO:    reg_rdata <= {15'h0, echo_q}; // [RQ5]
					`KK_REG_INT_MASK:      reg_rdata <= {8'h0, mask_q & `KK_MASK_USED}; // [RQ17]
					`KK_REG_LANGUAGE:      reg_rdata <= (language_jumper > `KK_LANG_MAX) ? 16'h0
						: {13'h0, language_jumper}; // [RQ8]
					`KK_REG_CONFIG:        reg_rdata <= (config_jumper > `KK_CONFIG_MAX) ? 16'h0
						: {12'h0, config_jumper}; // [RQ9]
					`KK_REG_KNOB_MODIFIER: reg_rdata <= {14'h0, knob_mod_q}; // [RQ10]
					`KK_REG_END_MARKER:    reg_rdata <= {15'h0, eot_q}; // [RQ11]
					`KK_REG_KANA_MODE:     reg_rdata <= {15'h0, kana_q}; // [RQ12]
					default:               reg_rdata <= 16'h0;
				endcase
			end
		end
	end

	// Knob count and mode flag outputs
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			knob_pulse_count       <= 8'h0;
			letter_case_lock       <= 1'b0;
			print_echo             <= 1'b0;
			end_of_transfer_marker <= 1'b0;
			kana_mode              <= 1'b0;
		end else begin
			knob_pulse_count       <= knob_count; // [RQ16]
			letter_case_lock       <= case_q;
			print_echo             <= echo_q;
			end_of_transfer_marker <= eot_q;
			kana_mode              <= kana_q;
		end
	end
endmodule

// *** verification/kbknob_assertions.sv ***
// Port-level checks on the keyboard and knob register set
`timescale 1ns/10ps
`include "kbknob_regs.svh"
module kbknob_assertions (
	// Clock and reset
	input wire logic                      sys_clk,
	input wire logic                      arst_n,
	// Register port
	input wire logic [3:0]                reg_addr,
	input wire logic                      reg_wr,
	input wire logic                      reg_rd,
	input wire logic [15:0]               reg_wdata,
	input wire logic [15:0]               reg_rdata,
	// Operator side and outputs
	input wire kbknob_pkg::kbknob_key_t   key_in,
	input wire kbknob_pkg::kbknob_pulse_t knob_in,
	input wire logic                      init_timeout,
	input wire logic [2:0]                language_jumper,
	input wire logic                      knob_trap_active,
	input wire logic                      suspend_interactive,
	input wire kbknob_pkg::kbknob_out_t   key_out,
	input wire logic                      reset_event,
	input wire logic                      init_timeout_event,
	input wire logic                      letter_case_lock,
	input wire logic                      end_of_transfer_marker
);
	logic [7:0] mask_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_q <= 8'h00;
		end else if (reg_wr && reg_addr == 4'h7) begin
			mask_q <= reg_wdata[7:0];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// No code sequence can still be in flight
	sequence quiet_s; !key_out.valid && !$past(key_in.valid) && !$past(knob_in.valid); endsequence
	sequence knob_go_s; knob_in.valid && !knob_in.ctrl && !knob_trap_active && !mask_q[0] ##0 quiet_s; endsequence
	sequence knob_codes_s;
		key_out.valid && key_out.code == 8'hff ##1
		key_out.valid && key_out.code == ($past(knob_in.clockwise, 2) ? 8'h5e : 8'h56);
	endsequence
	mask_upper_a: assert property (reg_rd && reg_addr == 4'h7 |=> reg_rdata[15:5] == 11'h0)
		else $error("mask readback upper bits set");
	// The flag outputs are registered copies, so they follow a write by two edges
	case_lock_a: assert property (reg_wr && reg_addr == 4'h0 |-> ##2
		letter_case_lock == ($past(reg_wdata, 2) != 16'h0000))
		else $error("case lock flag wrong");
	end_marker_a: assert property (reg_wr && reg_addr == 4'hc |-> ##2
		end_of_transfer_marker == ($past(reg_wdata, 2) != 16'h0000))
		else $error("end marker flag wrong");
	lang_read_a: assert property (reg_rd && reg_addr == 4'h8 && language_jumper <= 3'h5 |=>
		reg_rdata == {13'h0, $past(language_jumper)})
		else $error("language readback wrong");
	knob_code_a: assert property (knob_go_s |=> knob_codes_s)
		else $error("knob cursor codes wrong");
	key_lock_a: assert property ((key_in.valid && !key_in.is_reset || knob_in.valid) && mask_q[0] ##0 quiet_s |=> !key_out.valid)
		else $error("locked key produced a code");
	reset_mask_a: assert property (key_in.valid && key_in.is_reset && mask_q[1] ##0 quiet_s |=> !reset_event)
		else $error("masked reset key reported");
	init_mask_a: assert property (init_timeout && mask_q[4] && !$past(init_timeout) |=> !init_timeout_event)
		else $error("masked init timeout reported");
	suspend_keys_a: assert property (key_in.valid && !knob_in.valid && key_in.is_interactive && !key_in.is_reset
		&& suspend_interactive ##0 quiet_s |=> !key_out.valid)
		else $error("suspended key produced a code");
endmodule
bind kbknob_ctrl kbknob_assertions i_kbknob_assertions (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .key_in(key_in),
	.knob_in(knob_in), .init_timeout(init_timeout), .language_jumper(language_jumper),
	.knob_trap_active(knob_trap_active), .suspend_interactive(suspend_interactive), .key_out(key_out),
	.reset_event(reset_event), .init_timeout_event(init_timeout_event), .letter_case_lock(letter_case_lock),
	.end_of_transfer_marker(end_of_transfer_marker));

// *** verification/kbknob_operator.sv ***
// Operator model: keys, knob, init timeout and jumpers
`timescale 1ns/10ps
module kbknob_operator (
	// Clock
	input wire logic                  sys_clk,
	// Operator side
	output kbknob_pkg::kbknob_key_t   key_in,
	output logic                      key_held,
	output kbknob_pkg::kbknob_pulse_t knob_in,
	output logic                      init_timeout,
	output logic [2:0]                language_jumper,
	output logic [3:0]                config_jumper
);
	initial begin
		key_in = '0;
		key_held = 1'b0;
		knob_in = '0;
		init_timeout = 1'b0;
		language_jumper = 3'h0;
		config_jumper = 4'h0;
	end
	// Kind is {ascii, reset, interactive, softkey}; ctrl is held only around the press
	task automatic press(input logic [7:0] code, input logic [3:0] kind, input logic ctrl);
		@(posedge sys_clk);
		#1;
		knob_in.ctrl = ctrl;
		key_in = {1'b1, code, kind};
		@(posedge sys_clk);
		#1;
		key_in = '0;
		knob_in.ctrl = 1'b0;
	endtask
	task automatic turn(input logic cw, input logic shift, input logic ctrl);
		@(posedge sys_clk);
		#1;
		knob_in = {1'b1, cw, shift, ctrl};
		@(posedge sys_clk);
		#1;
		knob_in = '0;
	endtask
	task automatic fire_timeout;
		@(posedge sys_clk);
		#1;
		init_timeout = 1'b1;
		@(posedge sys_clk);
		#1;
		init_timeout = 1'b0;
	endtask
	task automatic set_jumpers(input logic [2:0] lang, input logic [3:0] cfg);
		language_jumper = lang;
		config_jumper = cfg;
	endtask
endmodule

// *** verification/keyboard_knob_control_regs_test.sv ***
// Self-checking bench for the keyboard and knob register set
`timescale 1ns/10ps
`include "kbknob_regs.svh"
module keyboard_knob_control_regs_test;
	logic                      sys_clk, arst_n, reg_wr, reg_rd, reg_rvalid, knob_read, key_held, init_timeout;
	logic [3:0]                reg_addr, config_jumper, fl;
	logic [15:0]               reg_wdata, reg_rdata;
	logic [7:0]                knob_pulse_count;
	logic [2:0]                language_jumper;
	logic [23:0]               cd;
	logic                      knob_trap_active, kbd_trap_active, kbd_trap_all, suspend_interactive, suspend_reset;
	logic                      knob_event, reset_event, init_timeout_event;
	logic                      letter_case_lock, print_echo, end_of_transfer_marker, kana_mode;
	kbknob_pkg::kbknob_key_t   key_in;
	kbknob_pkg::kbknob_pulse_t knob_in;
	kbknob_pkg::kbknob_out_t   key_out;
	int                        n_errors, tests_run;
	kbknob_ctrl i_kbknob_ctrl (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.knob_read(knob_read), .knob_pulse_count(knob_pulse_count), .key_in(key_in), .key_held(key_held),
		.knob_in(knob_in), .init_timeout(init_timeout), .language_jumper(language_jumper),
		.config_jumper(config_jumper), .knob_trap_active(knob_trap_active), .kbd_trap_active(kbd_trap_active),
		.kbd_trap_all(kbd_trap_all), .suspend_interactive(suspend_interactive), .suspend_reset(suspend_reset),
		.key_out(key_out), .knob_event(knob_event), .reset_event(reset_event),
		.init_timeout_event(init_timeout_event), .letter_case_lock(letter_case_lock), .print_echo(print_echo),
		.end_of_transfer_marker(end_of_transfer_marker), .kana_mode(kana_mode));
	kbknob_operator i_kbknob_operator (.sys_clk(sys_clk), .key_in(key_in), .key_held(key_held), .knob_in(knob_in),
		.init_timeout(init_timeout), .language_jumper(language_jumper), .config_jumper(config_jumper));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		#1;
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		#1;
		{reg_addr, reg_rd} = {a, 1'b1};
		@(posedge sys_clk);
		#1;
		reg_rd = 1'b0;
		check({7'h00, reg_rvalid, reg_rdata}, {8'h01, exp});
	endtask
	// Codes shift in oldest first; flags are {softkey, knob, reset, init timeout}
	task automatic collect;
		cd = 24'h000000;
		fl = 4'h0;
		repeat (5) begin
			@(negedge sys_clk);
			if (key_out.valid === 1'b1) cd = {cd[15:0], key_out.code};
			fl = fl | {key_out.valid & key_out.to_softkey, knob_event, reset_event, init_timeout_event};
		end
	endtask
	task automatic kev(input logic [7:0] c, input logic [3:0] k, input logic ct, input logic [23:0] ec, input logic [3:0] ef);
		i_kbknob_operator.press(c, k, ct);
		collect();
		if (!k[2]) check(cd, ec);
		check({20'h00000, fl}, {20'h00000, ef});
	endtask
	task automatic kn(input logic cw, input logic sh, input logic ct, input logic [23:0] ec, input logic [3:0] ef);
		i_kbknob_operator.turn(cw, sh, ct);
		collect();
		check(cd, ec);
		check({20'h00000, fl}, {20'h00000, ef});
	endtask
	task automatic lvl(input logic [4:0] v);
		@(posedge sys_clk);
		#1;
		{knob_trap_active, kbd_trap_active, kbd_trap_all, suspend_interactive, suspend_reset} = v;
	endtask
	task automatic count_is(input logic [7:0] e);
		repeat (2) @(posedge sys_clk);
		#1;
		check({16'h0000, knob_pulse_count}, {16'h0000, e});
	endtask
	task automatic finish_test;
		$display("Checks run: %0d, mismatches: %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		finish_test();
	end
	initial begin
		logic [3:0] fa [3];
		logic [3:0] fo [3];
		fa = '{4'h0, 4'h1, 4'hc};
		fo = '{4'h8, 4'h4, 4'h2};
		{arst_n, reg_wr, reg_rd, knob_read, reg_addr, reg_wdata} = '0;
		{knob_trap_active, kbd_trap_active, kbd_trap_all, suspend_interactive, suspend_reset} = 5'h00;
		repeat (16) @(posedge sys_clk);
		#1;
		arst_n = 1'b1;
		foreach (fa[i]) begin
			rdc(fa[i], 16'h0000);
			wr(fa[i], 16'h0100);
			rdc(fa[i], 16'h0001);
			check({20'h00000, letter_case_lock, print_echo, end_of_transfer_marker, kana_mode}, {20'h00000, fo[i]});
			wr(fa[i], 16'h0000);
		end
		i_kbknob_operator.set_jumpers(3'h5, 4'h0);
		wr(4'hd, 16'h0001);
		rdc(4'hd, 16'h0001);
		i_kbknob_operator.set_jumpers(3'h0, 4'h0);
		wr(4'hd, 16'h0000);
		wr(4'hd, 16'h0001);
		rdc(4'hd, 16'h0000);
		check({23'h000000, kana_mode}, 24'h000000);
		rdc(4'h7, 16'h0000);
		wr(4'h7, 16'h00ff);
		rdc(4'h7, {8'h00, `KK_MASK_USED});
		wr(4'h7, 16'h0000);
		rdc(4'h5, 16'h0000);
		for (int i = 0; i < 10; i++) begin
			i_kbknob_operator.set_jumpers((i > 5) ? 3'h6 : 3'(i), 4'(i));
			wr(4'h9, 16'h00ff);
			rdc(4'h8, (i > 5) ? 16'h0000 : 16'(i));
			rdc(4'h9, (i > 8) ? 16'h0000 : 16'(i));
		end
		kn(1'b1, 1'b0, 1'b0, 24'h00ff5e, 4'h0);
		kn(1'b0, 1'b0, 1'b0, 24'h00ff56, 4'h0);
		lvl(5'h10);
		for (int m = 1; m < 4; m++) begin
			kn(1'b1, m[0], m[1], 24'h000000, 4'h4);
			rdc(4'ha, 16'(m));
		end
		@(posedge sys_clk);
		#1 knob_read = 1'b1;
		@(posedge sys_clk);
		#1 knob_read = 1'b0;
		count_is(8'h00);
		repeat (2) i_kbknob_operator.turn(1'b1, 1'b0, 1'b0);
		repeat (5) i_kbknob_operator.turn(1'b0, 1'b0, 1'b0);
		count_is(8'hfd);
		repeat (140) i_kbknob_operator.turn(1'b1, 1'b0, 1'b0);
		count_is(8'h7f);
		lvl(5'h00);
		kev(8'h45, 4'h0, 1'b0, 24'h00ff45, 4'h0);
		kev(8'h45, 4'h0, 1'b1, 24'hffff45, 4'h0);
		kev(8'h41, 4'h8, 1'b0, 24'h000041, 4'h0);
		kev(8'h70, 4'h1, 1'b0, 24'h00ff70, 4'h8);
		lvl(5'h0c);
		kev(8'h70, 4'h1, 1'b0, 24'h00ff70, 4'h0);
		lvl(5'h00);
		wr(4'h7, 16'h0001);
		kev(8'h45, 4'h0, 1'b0, 24'h000000, 4'h0);
		kn(1'b1, 1'b0, 1'b0, 24'h000000, 4'h0);
		kev(8'h52, 4'h4, 1'b0, 24'h000000, 4'h2);
		wr(4'h7, 16'h0002);
		kev(8'h52, 4'h4, 1'b0, 24'h000000, 4'h0);
		wr(4'h7, 16'h0010);
		i_kbknob_operator.fire_timeout();
		collect();
		check({20'h00000, fl}, 24'h000000);
		wr(4'h7, 16'h0000);
		i_kbknob_operator.fire_timeout();
		collect();
		check({20'h00000, fl}, 24'h000001);
		lvl(5'h02);
		kev(8'h45, 4'h2, 1'b0, 24'h000000, 4'h0);
		kev(8'h52, 4'h4, 1'b0, 24'h000000, 4'h2);
		lvl(5'h03);
		kev(8'h52, 4'h4, 1'b0, 24'h000000, 4'h0);
		lvl(5'h00);
		kev(8'h45, 4'h2, 1'b0, 24'h00ff45, 4'h0);
		finish_test();
	end
endmodule
